// ===== verilog/tfe_pkg.sv
// Shared constants and types of the technology-function event and job block
// Assumes one 20 MHz clock and an AXI4-Lite register bus with 8-bit byte addresses
package tfe_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_JOB_CH = 8'h04;
  localparam logic [7:0] OFS_JOB_IDENTIFIER = 8'h08;
  localparam logic [7:0] OFS_JOB_WRITE_VALUE = 8'h0c;
  localparam logic [7:0] OFS_JOB_REQ = 8'h10;
  localparam logic [7:0] OFS_JOB_STAT = 8'h14;
  localparam logic [7:0] OFS_JOB_READ_VALUE = 8'h1c;
  localparam logic [7:0] OFS_TRIG_EN = 8'h20;
  localparam logic [7:0] OFS_EVT = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_BASE = 8'h2c;
  localparam logic [3:0] OFS_DUTY_HI = 4'h3;

  // ==========================================================
  // Control fields
  localparam int CTRL_DIAG_PROC_BIT = 0;
  localparam int CTRL_CNT_OUT_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SWEN_LSB = 8;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_CODE_LSB = 16;

  // ==========================================================
  // Event word lanes
  localparam int EVT_IN_LSB = 0;
  localparam int EVT_CNT_LSB = 16;
  localparam int NUM_CNT = 4;
  localparam int NUM_IN = 16;

  // ==========================================================
  // Job identifiers and status codes
  localparam logic [15:0] JOB_NONE = 16'h0000;
  localparam logic [15:0] JOB_WR_PER = 16'h0001;
  localparam logic [15:0] JOB_WR_DLY = 16'h0002;
  localparam logic [15:0] JOB_WR_MIN = 16'h0004;
  localparam logic [15:0] JOB_RD_PER = 16'h0081;
  localparam logic [15:0] JOB_RD_DLY = 16'h0082;
  localparam logic [15:0] JOB_RD_MIN = 16'h0084;
  localparam logic [15:0] ST_OK = 16'h0000;
  localparam logic [15:0] ST_PER_LO = 16'h0411;
  localparam logic [15:0] ST_PER_HI = 16'h0412;
  localparam logic [15:0] ST_DLY_LO = 16'h0421;
  localparam logic [15:0] ST_DLY_HI = 16'h0422;
  localparam logic [15:0] ST_MIN_LO = 16'h0431;
  localparam logic [15:0] ST_MIN_HI = 16'h0432;
  localparam logic [15:0] ST_BAD_ID = 16'h04ff;
  localparam logic [15:0] ST_PARAM = 16'h8001;
  localparam logic [15:0] ST_CHAN = 16'h8009;
  localparam logic [7:0] CH_ABS_MAX = 8'h03;

  // ==========================================================
  // Reset values
  localparam logic [31:0] PER_RST = 32'h0000_03e8;
  localparam logic [31:0] DLY_RST = 32'h0000_0000;
  localparam logic [31:0] MIN_RST = 32'h0000_0000;
  localparam logic [31:0] DUTY_RST = 32'h0000_01f4;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_COUNT = 2'b00,
    MODE_FREQ = 2'b01,
    MODE_PWM = 2'b10
  } tfe_mode_e;

  typedef enum logic {
    JS_IDLE = 1'b0,
    JS_EXEC = 1'b1
  } tfe_job_e;

  // Counter event pulses, gate_open in bit 0
  typedef struct packed {
    logic cmp;
    logic endv;
    logic unf;
    logic ovf;
    logic gate_close;
    logic gate_open;
  } tfe_cnt_evt_s;

  typedef struct packed {
    logic [31:0] per;
    logic [31:0] dly;
    logic [31:0] min;
    logic [31:0] duty;
  } tfe_pwm_par_s;

endpackage

// ===== verilog/tfe_pwm_chan.sv
// One pulse-width channel with shadowed period parameters
// Assumes parameters are counted in clock ticks and gate is a level
`timescale 1ns/1ns
`default_nettype none
module tfe_pwm_chan (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic gate,
  input wire tfe_pkg::tfe_pwm_par_s par,
  output logic pwm_out
);

  logic [31:0] cnt_r, cnt_nxt;
  tfe_pkg::tfe_pwm_par_s sh_r, sh_nxt;
  logic out_r, out_nxt;
  tfe_pkg::tfe_pwm_par_s eff;
  logic [31:0] wid;

  // ==========================================================
  // Period counter and shadow load
  always_comb begin
    eff = (cnt_r == 32'h0000_0000) ? par : sh_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    wid = (eff.duty > eff.min) ? eff.duty : eff.min;
    out_nxt = 1'b0;
    if (!gate) begin
      cnt_nxt = 32'h0000_0000;
    end else begin
      if (cnt_r == 32'h0000_0000) begin
        sh_nxt = par;
      end
      if (cnt_r + 32'h0000_0001 >= eff.per) begin
        cnt_nxt = 32'h0000_0000;
      end else begin
        cnt_nxt = cnt_r + 32'h0000_0001;
      end
      out_nxt = (cnt_r >= eff.dly) && (cnt_r - eff.dly < wid);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0000_0000;
      sh_r <= '0;
      out_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
    end
  end

  assign pwm_out = out_r;

endmodule
`default_nettype wire

// ===== verilog/tfe_event_job.sv
// Technology-function event flags, process interrupt and pulse job engine
// Assumes an AXI4-Lite master and event pulses synchronous to clk
//
// Functional notes
// - Minimum pulse too high 0432h, bad ID 04FFh
// - Channel above 3 rejected with 8009h
// - Channel above unit maximum gives 8001h
// - Read job value returned at offset 28
// - New pulse values apply at next period
// - Counter triggers: edge, gate, compare, limits
// - Frequency triggers: edge and measurement end
// - Pulse function never raises process interrupt
// - Interrupt needs counter output and diagnostics
// - Event bytes 8 and 9 hold input edges
// - Event byte 10 holds counters 0 and 1
// - Event byte 11 holds counters 2 and 3
// - Interrupt supplies module base address
// - Job identifier encoding for write and read
`timescale 1ns/1ns
`default_nettype none
module tfe_event_job #(
  parameter int NUM_CH = 4,
  parameter logic signed [31:0] PER_MIN = 32'sh0000_0002,
  parameter logic signed [31:0] PER_MAX = 32'sh0000_ffff,
  parameter logic signed [31:0] DLY_MIN = 32'sh0000_0000,
  parameter logic signed [31:0] DLY_MAX = 32'sh0000_ffff,
  parameter logic signed [31:0] MIN_MIN = 32'sh0000_0000,
  parameter logic signed [31:0] MIN_MAX = 32'sh0000_ffff
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] in_edge,
  input wire tfe_pkg::tfe_cnt_evt_s [3:0] cnt_evt,
  input wire logic [3:0] meas_end,
  output logic [3:0] pwm_out,
  output logic proc_irq,
  output logic [31:0] proc_event_word,
  output logic [15:0] proc_base_addr,
  output logic job_done,
  output logic job_error
);

  // ==========================================================
  // State
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, trig_r, trig_nxt, evt_r, evt_nxt, mask_r, mask_nxt;
  logic [15:0] base_r, base_nxt, job_identifier_r, job_identifier_nxt, stat_r, stat_nxt;
  logic [7:0] job_ch_r, job_ch_nxt;
  logic [31:0] job_write_value_r, job_write_value_nxt, oval_r, oval_nxt;
  logic req_r, req_nxt, req_prev_r, err_r, err_nxt;
  tfe_pkg::tfe_job_e js_r, js_nxt;
  tfe_pkg::tfe_pwm_par_s par_r [4];
  tfe_pkg::tfe_pwm_par_s par_nxt [4];
  logic do_wr, wr_ok, rd_hs, rd_evt;
  logic [31:0] evt_raw;
  logic [3:0] swen;
  logic [1:0] ch;
  logic signed [31:0] sval;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign swen = ctrl_r[tfe_pkg::CTRL_SWEN_LSB +: 4];
  assign ch = job_ch_r[1:0];
  assign sval = job_write_value_r;
  assign s_axi_awready = ce && !aw_hold_r && !bvalid_r;
  assign s_axi_wready = ce && !w_hold_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  assign rd_evt = rd_hs && (s_axi_araddr == tfe_pkg::OFS_EVT);

  // ==========================================================
  // Event word assembly
  always_comb begin
    evt_raw = 32'h0000_0000;
    unique case (tfe_pkg::tfe_mode_e'(ctrl_r[tfe_pkg::CTRL_MODE_LSB +: 2]))
      tfe_pkg::MODE_COUNT: begin
        evt_raw[tfe_pkg::EVT_IN_LSB +: tfe_pkg::NUM_IN] = in_edge;
        for (int c = 0; c < tfe_pkg::NUM_CNT; c++) begin
          evt_raw[tfe_pkg::EVT_CNT_LSB + 4*c +: 4] = {
            cnt_evt[c].cmp,
            cnt_evt[c].ovf | cnt_evt[c].unf | cnt_evt[c].endv,
            cnt_evt[c].gate_close & swen[c],
            cnt_evt[c].gate_open & swen[c]};
        end
      end
      tfe_pkg::MODE_FREQ: begin
        evt_raw[tfe_pkg::EVT_IN_LSB +: tfe_pkg::NUM_IN] = in_edge;
        for (int c = 0; c < tfe_pkg::NUM_CNT; c++) begin
          evt_raw[tfe_pkg::EVT_CNT_LSB + 4*c] = meas_end[c];
        end
      end
      tfe_pkg::MODE_PWM: evt_raw = 32'h0000_0000;
      default: evt_raw = 32'h0000_0000;
    endcase
    evt_raw = evt_raw & trig_r;
  end

  // ==========================================================
  // Bus, registers, events and job engine
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    awaddr_nxt = awaddr_r;
    w_hold_nxt = w_hold_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    trig_nxt = trig_r;
    mask_nxt = mask_r;
    base_nxt = base_r;
    job_ch_nxt = job_ch_r;
    job_identifier_nxt = job_identifier_r;
    job_write_value_nxt = job_write_value_r;
    req_nxt = req_r;
    stat_nxt = stat_r;
    err_nxt = err_r;
    oval_nxt = oval_r;
    js_nxt = js_r;
    par_nxt = par_r;
    wr_ok = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (awaddr_r[7:4] == tfe_pkg::OFS_DUTY_HI && awaddr_r[1:0] == 2'h0) begin
        par_nxt[awaddr_r[3:2]].duty = merge(par_r[awaddr_r[3:2]].duty, wdata_r, wstrb_r);
      end else begin
        unique case (awaddr_r)
          tfe_pkg::OFS_CTRL: ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r);
          tfe_pkg::OFS_JOB_CH: job_ch_nxt = 8'(merge({24'h00_0000, job_ch_r}, wdata_r, wstrb_r));
          tfe_pkg::OFS_JOB_IDENTIFIER: job_identifier_nxt = 16'(merge({16'h0000, job_identifier_r}, wdata_r, wstrb_r));
          tfe_pkg::OFS_JOB_WRITE_VALUE: job_write_value_nxt = merge(job_write_value_r, wdata_r, wstrb_r);
          tfe_pkg::OFS_JOB_REQ: req_nxt = wstrb_r[0] ? wdata_r[0] : req_r;
          tfe_pkg::OFS_TRIG_EN: trig_nxt = merge(trig_r, wdata_r, wstrb_r);
          tfe_pkg::OFS_MASK: mask_nxt = merge(mask_r, wdata_r, wstrb_r);
          tfe_pkg::OFS_BASE: base_nxt = 16'(merge({16'h0000, base_r}, wdata_r, wstrb_r));
          tfe_pkg::OFS_JOB_STAT, tfe_pkg::OFS_JOB_READ_VALUE, tfe_pkg::OFS_EVT: wr_ok = 1'b1;
          default: wr_ok = 1'b0;
        endcase
      end
      bresp_nxt = wr_ok ? tfe_pkg::RESP_OKAY : tfe_pkg::RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_hs) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = tfe_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr[7:4] == tfe_pkg::OFS_DUTY_HI && s_axi_araddr[1:0] == 2'h0) begin
        rdata_nxt = par_r[s_axi_araddr[3:2]].duty;
      end else begin
        unique case (s_axi_araddr)
          tfe_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
          tfe_pkg::OFS_JOB_CH: rdata_nxt = {24'h00_0000, job_ch_r};
          tfe_pkg::OFS_JOB_IDENTIFIER: rdata_nxt = {16'h0000, job_identifier_r};
          tfe_pkg::OFS_JOB_WRITE_VALUE: rdata_nxt = job_write_value_r;
          tfe_pkg::OFS_JOB_REQ: rdata_nxt = {31'h0000_0000, req_r};
          tfe_pkg::OFS_JOB_STAT: rdata_nxt = {stat_r, 14'h0000, err_r, js_r == tfe_pkg::JS_IDLE};
          tfe_pkg::OFS_JOB_READ_VALUE: rdata_nxt = oval_r;
          tfe_pkg::OFS_TRIG_EN: rdata_nxt = trig_r;
          tfe_pkg::OFS_EVT: rdata_nxt = evt_r;
          tfe_pkg::OFS_MASK: rdata_nxt = mask_r;
          tfe_pkg::OFS_BASE: rdata_nxt = {16'h0000, base_r};
          default: rresp_nxt = tfe_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Delivered flags drop on event word read; new events win
    evt_nxt = (evt_r & ~(rd_evt ? evt_r : 32'h0000_0000)) | evt_raw;
    unique case (js_r)
      tfe_pkg::JS_IDLE: begin
        if (req_r && !req_prev_r) begin
          js_nxt = tfe_pkg::JS_EXEC;
        end
      end
      tfe_pkg::JS_EXEC: begin
        js_nxt = tfe_pkg::JS_IDLE;
        stat_nxt = tfe_pkg::ST_OK;
        if (job_ch_r > tfe_pkg::CH_ABS_MAX) begin
          stat_nxt = tfe_pkg::ST_CHAN;
        end else if (job_ch_r > 8'(NUM_CH - 1)) begin
          stat_nxt = tfe_pkg::ST_PARAM;
        end else begin
          unique case (job_identifier_r)
            tfe_pkg::JOB_NONE: stat_nxt = tfe_pkg::ST_OK;
            tfe_pkg::JOB_WR_PER: begin
              if (sval < PER_MIN) stat_nxt = tfe_pkg::ST_PER_LO;
              else if (sval > PER_MAX) stat_nxt = tfe_pkg::ST_PER_HI;
              else par_nxt[ch].per = job_write_value_r;
            end
            tfe_pkg::JOB_WR_DLY: begin
              if (sval < DLY_MIN) stat_nxt = tfe_pkg::ST_DLY_LO;
              else if (sval > DLY_MAX) stat_nxt = tfe_pkg::ST_DLY_HI;
              else par_nxt[ch].dly = job_write_value_r;
            end
            tfe_pkg::JOB_WR_MIN: begin
              if (sval < MIN_MIN) stat_nxt = tfe_pkg::ST_MIN_LO;
              else if (sval > MIN_MAX) stat_nxt = tfe_pkg::ST_MIN_HI;
              else par_nxt[ch].min = job_write_value_r;
            end
            tfe_pkg::JOB_RD_PER: oval_nxt = par_r[ch].per;
            tfe_pkg::JOB_RD_DLY: oval_nxt = par_r[ch].dly;
            tfe_pkg::JOB_RD_MIN: oval_nxt = par_r[ch].min;
            default: stat_nxt = tfe_pkg::ST_BAD_ID;
          endcase
        end
        err_nxt = (stat_nxt != tfe_pkg::ST_OK);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= tfe_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= tfe_pkg::RESP_OKAY;
      ctrl_r <= 32'h0000_0000;
      trig_r <= 32'h0000_0000;
      evt_r <= 32'h0000_0000;
      mask_r <= 32'h0000_0000;
      base_r <= tfe_pkg::BASE_RST;
      job_ch_r <= 8'h00;
      job_identifier_r <= tfe_pkg::JOB_NONE;
      job_write_value_r <= 32'h0000_0000;
      req_r <= 1'b0;
      req_prev_r <= 1'b0;
      stat_r <= tfe_pkg::ST_OK;
      err_r <= 1'b0;
      oval_r <= 32'h0000_0000;
      js_r <= tfe_pkg::JS_IDLE;
      for (int c = 0; c < 4; c++) begin
        par_r[c] <= {tfe_pkg::PER_RST, tfe_pkg::DLY_RST, tfe_pkg::MIN_RST, tfe_pkg::DUTY_RST};
      end
    end else if (ce) begin
      aw_hold_r <= aw_hold_nxt;
      awaddr_r <= awaddr_nxt;
      w_hold_r <= w_hold_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      trig_r <= trig_nxt;
      evt_r <= evt_nxt;
      mask_r <= mask_nxt;
      base_r <= base_nxt;
      job_ch_r <= job_ch_nxt;
      job_identifier_r <= job_identifier_nxt;
      job_write_value_r <= job_write_value_nxt;
      req_r <= req_nxt;
      req_prev_r <= req_r;
      stat_r <= stat_nxt;
      err_r <= err_nxt;
      oval_r <= oval_nxt;
      js_r <= js_nxt;
      par_r <= par_nxt;
    end
  end

  // ==========================================================
  // Pulse channels
  for (genvar g = 0; g < 4; g++) begin : g_pwm
    tfe_pwm_chan u_chan (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .gate(swen[g] && ctrl_r[tfe_pkg::CTRL_MODE_LSB +: 2] == tfe_pkg::MODE_PWM),
      .par(par_r[g]),
      .pwm_out(pwm_out[g])
    );
  end

  // ==========================================================
  // Outputs
  assign proc_irq = ctrl_r[tfe_pkg::CTRL_CNT_OUT_BIT] && ctrl_r[tfe_pkg::CTRL_DIAG_PROC_BIT]
                    && |(evt_r & mask_r);
  assign proc_event_word = evt_r;
  assign proc_base_addr = base_r;
  assign job_done = (js_r == tfe_pkg::JS_IDLE);
  assign job_error = err_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

// ===== testbench/tfe_event_job_chk.sv
// Port-level assertions for the event and job block
// Assumes it is bound onto tfe_event_job, one clock domain
`timescale 1ns/1ns
`default_nettype none
module tfe_event_job_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic proc_irq,
  input wire logic [31:0] proc_event_word,
  input wire logic job_done
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ce_stall: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready while stalled");
  a_irq_cause: assert property (proc_irq |-> proc_event_word != 32'h0)
    else $error("interrupt without event flag");
  a_evt_sticky: assert property (!(s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == tfe_pkg::OFS_EVT) |=>
    (proc_event_word & $past(proc_event_word)) == $past(proc_event_word))
    else $error("event flag lost without read");
  a_done_short: assert property ($fell(job_done) |=> job_done || !$past(ce))
    else $error("job engine stuck busy");
  cover property (proc_irq);
  cover property ($fell(job_done));
  cover property (proc_event_word[31:16] != 16'h0);
endmodule
bind tfe_event_job tfe_event_job_chk tfe_event_job_chk_inst (
  .clk(clk), .rst_b(rst_b), .ce(ce), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .proc_irq(proc_irq), .proc_event_word(proc_event_word),
  .job_done(job_done));
`default_nettype wire

// ===== testbench/test_tfe_event_job.sv
// Self-checking bench for the event and job block
// Assumes a 20 MHz clock and the AXI4-Lite map of tfe_pkg
`timescale 1ns/1ns
`default_nettype none
module test_tfe_event_job;
  logic clk, rst_b, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, proc_irq, job_done, job_error;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ev, d;
  logic [3:0] wstrb, meas_end, pwm_out;
  logic [1:0] bresp, rresp, r;
  logic [15:0] in_edge, base;
  tfe_pkg::tfe_cnt_evt_s [3:0] cnt_evt;
  int bad_count, cmp_count, n;
  tfe_event_job #(.NUM_CH(2)) tfe_event_job_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_edge(in_edge), .cnt_evt(cnt_evt), .meas_end(meas_end), .pwm_out(pwm_out),
    .proc_irq(proc_irq), .proc_event_word(ev), .proc_base_addr(base), .job_done(job_done),
    .job_error(job_error));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bv, done;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bv = bvalid;
      done = bvalid & bready;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bv && !done) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic at, rv, done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      at = arvalid & arready;
      rv = rvalid;
      done = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      if (rv && !done) rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask
  task automatic job(input logic [7:0] ch, input logic [15:0] id, input logic [31:0] v,
                     input logic [15:0] code);
    chk(job_done, 1'b1);
    wr(tfe_pkg::OFS_JOB_CH, {24'h0, ch});
    wr(tfe_pkg::OFS_JOB_IDENTIFIER, {16'h0, id});
    wr(tfe_pkg::OFS_JOB_WRITE_VALUE, v);
    wr(tfe_pkg::OFS_JOB_REQ, 32'h1);
    wr(tfe_pkg::OFS_JOB_REQ, 32'h0);
    rd(tfe_pkg::OFS_JOB_STAT);
    chk(d, {code, 14'h0, |code, 1'b1});
    chk(job_error, |code);
  endtask
  task automatic pulse(input logic [15:0] e, input logic [23:0] c, input logic [3:0] m);
    @(posedge clk);
    in_edge <= e;
    cnt_evt <= c;
    meas_end <= m;
    @(posedge clk);
    in_edge <= 16'h0;
    cnt_evt <= 24'h0;
    meas_end <= 4'h0;
    @(negedge clk);
  endtask
  task automatic count_pwm();
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += pwm_out[0];
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {in_edge, cnt_evt, meas_end} = '0;
    wstrb = 4'hf;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    chk(pwm_out, 4'h0);
    chk(ev, 32'h0);
    $display("test reset done");
    job(8'h0, tfe_pkg::JOB_NONE, 32'h0, tfe_pkg::ST_OK);
    job(8'h0, tfe_pkg::JOB_WR_PER, 32'd100, tfe_pkg::ST_OK);
    job(8'h0, tfe_pkg::JOB_WR_DLY, 32'd5, tfe_pkg::ST_OK);
    job(8'h0, tfe_pkg::JOB_WR_MIN, 32'd7, tfe_pkg::ST_OK);
    job(8'h0, tfe_pkg::JOB_RD_PER, 32'h0, tfe_pkg::ST_OK);
    rd(tfe_pkg::OFS_JOB_READ_VALUE);
    chk(d, 32'd100);
    job(8'h0, tfe_pkg::JOB_RD_DLY, 32'h0, tfe_pkg::ST_OK);
    rd(tfe_pkg::OFS_JOB_READ_VALUE);
    chk(d, 32'd5);
    job(8'h0, tfe_pkg::JOB_RD_MIN, 32'h0, tfe_pkg::ST_OK);
    rd(tfe_pkg::OFS_JOB_READ_VALUE);
    chk(d, 32'd7);
    job(8'h0, tfe_pkg::JOB_WR_PER, 32'h1, tfe_pkg::ST_PER_LO);
    job(8'h0, tfe_pkg::JOB_WR_PER, 32'h10000, tfe_pkg::ST_PER_HI);
    job(8'h0, tfe_pkg::JOB_WR_DLY, 32'hffff_ffff, tfe_pkg::ST_DLY_LO);
    job(8'h0, tfe_pkg::JOB_WR_DLY, 32'h10000, tfe_pkg::ST_DLY_HI);
    job(8'h0, tfe_pkg::JOB_WR_MIN, 32'hffff_ffff, tfe_pkg::ST_MIN_LO);
    job(8'h0, tfe_pkg::JOB_WR_MIN, 32'h10000, tfe_pkg::ST_MIN_HI);
    job(8'h0, 16'h0033, 32'h0, tfe_pkg::ST_BAD_ID);
    job(8'h4, tfe_pkg::JOB_WR_PER, 32'd100, tfe_pkg::ST_CHAN);
    job(8'h2, tfe_pkg::JOB_WR_PER, 32'd100, tfe_pkg::ST_PARAM);
    job(8'h3, tfe_pkg::JOB_RD_PER, 32'h0, tfe_pkg::ST_PARAM);
    $display("test jobs done");
    wr(tfe_pkg::OFS_TRIG_EN, 32'hffff_ffff);
    wr(tfe_pkg::OFS_MASK, 32'hffff_ffff);
    wr(tfe_pkg::OFS_BASE, 32'h1234);
    chk(base, 16'h1234);
    wstrb <= 4'h1;
    wr(tfe_pkg::OFS_BASE, 32'hffff_ff56);
    chk(base, 16'h1256);
    wstrb <= 4'hf;
    wr(tfe_pkg::OFS_CTRL, 32'h101);
    pulse(16'h8001, {6'b001000, 6'b100000, 6'b000110, 6'b010001}, 4'h0);
    chk(ev, 32'h4845_8001);
    chk(proc_irq, 1'b0);
    wr(tfe_pkg::OFS_CTRL, 32'h103);
    chk(proc_irq, 1'b1);
    wr(tfe_pkg::OFS_MASK, 32'h0);
    chk(proc_irq, 1'b0);
    wr(tfe_pkg::OFS_MASK, 32'hffff_ffff);
    rd(tfe_pkg::OFS_EVT);
    chk(d, 32'h4845_8001);
    chk(proc_irq, 1'b0);
    rd(tfe_pkg::OFS_EVT);
    chk(d, 32'h0);
    wr(tfe_pkg::OFS_TRIG_EN, 32'h1);
    pulse(16'h0003, 24'h0, 4'h0);
    chk(ev, 32'h1);
    rd(tfe_pkg::OFS_EVT);
    wr(tfe_pkg::OFS_TRIG_EN, 32'hffff_ffff);
    wr(tfe_pkg::OFS_CTRL, 32'h113);
    pulse(16'h0100, {4{6'b111111}}, 4'hf);
    chk(ev, 32'h1111_0100);
    rd(tfe_pkg::OFS_EVT);
    wr(tfe_pkg::OFS_CTRL, 32'h123);
    pulse(16'hffff, {4{6'b111111}}, 4'hf);
    chk(ev, 32'h0);
    chk(proc_irq, 1'b0);
    rd(8'hfc);
    chk(r, tfe_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'hf8, 32'h0);
    chk(r, tfe_pkg::RESP_SLVERR);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk(awready | wready | arready, 1'b0);
    ce <= 1'b1;
    $display("test events done");
    wr(8'h30, 32'd20);
    count_pwm();
    chk(n != 0, 1'b1);
    chk(pwm_out[3:1], 3'h0);
    wr(tfe_pkg::OFS_CTRL, 32'h023);
    repeat (5) @(posedge clk);
    count_pwm();
    chk(n, 0);
    $display("test pwm done");
    wrap_up();
  end
endmodule
`default_nettype wire
